// >>> dpg_pkg.sv
package dpg_pkg;

  // ==========================================================
  // Clock and programming time
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10;
  // Cell programming time in microseconds; a plain default, tune per process.
  localparam int NVM_PROG_TIME_US = 5000;
  localparam int NVM_PROG_CYCLES = (NVM_PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int NVM_CNT_W = 20;

  // ==========================================================
  // Data-space map
  // ==========================================================
  localparam logic [7:0] ADDR_WIN_POS = 8'hc9;
  localparam logic [7:0] ADDR_BANK_SEL = 8'hcb;
  localparam logic [7:0] ADDR_NVM_CTL = 8'hdf;
  localparam logic [1:0] REGION_PAGED = 2'h0;
  localparam logic [1:0] REGION_WINDOW = 2'h1;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BANK_NVM_PAGE0 = 0;
  localparam int BANK_NVM_PAGE1 = 1;
  localparam int BANK_RAM_PAGE1 = 3;
  localparam int BANK_RAM_PAGE2 = 4;
  localparam int CTL_PROG_ENABLE = 0;
  localparam int CTL_BUSY = 1;
  localparam int CTL_ROW_MODE = 2;
  localparam int CTL_ROW_START = 3;
  localparam int CTL_STANDBY = 6;

  // ==========================================================
  // Reset values and sizes
  // ==========================================================
  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam logic [19:0] CNT_RESET = 20'h00000;
  localparam int PAGE_BYTES = 64;
  localparam int ROW_BYTES = 8;

  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dpg_cpu_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } dpg_cpu_rsp_t;

  typedef struct packed {
    logic [12:0] addr;
    logic rd;
  } dpg_pm_req_t;

endpackage

// >>> dpg_paging_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Data 40h-7Fh reads a program-memory window.
// - Window address is position over low six bits.
// - Window position is write-only at C9h.
// - Window position survives reset; software writes first.
// - Bank select one-hot: NVM0, NVM1, RAM1, RAM2.
// - Data 00h-3Fh routes into selected page.
// - Bank select is write-only at CBh.
// - Bank select survives reset; software writes first.
// - No bank or standby makes NVM access void.
// - Programming starts only with enable bit set.
// - Busy stays high for whole programming cycle.
// - Idle NVM reads like ordinary data location.
// - Byte mode and eight-byte row mode writes.
// - Control writes ignored while busy; busy readable.
// - Row mode latches first row; others ignored.
// - Entering row mode clears latches; only written bytes programmed.
// - Row mode enable clears at cycle end.
// - Row start needs enable and row mode set.
// - Row start bit clears when programming finishes.
// - Busy at bit 1; access while busy aborted.
// - Row is page bit and A5-A3; A2-A0 pick byte.
// - Enable at bit 0; disabled byte writes do nothing, row mode still latches.
module dpg_paging_ctrl #(
  parameter int unsigned PROG_CYCLES = dpg_pkg::NVM_PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire dpg_pkg::dpg_cpu_req_t cpu_req,
  output dpg_pkg::dpg_cpu_rsp_t cpu_rsp,
  output dpg_pkg::dpg_pm_req_t pm_req,
  input wire logic [7:0] pm_rdata,
  output logic nvm_busy
);
  import dpg_pkg::*;

  typedef struct packed {
    logic [5:0] window_page_bits;
    logic [7:0] page_bank_select;
    // Marks which write-only register has been loaded; neither is reset, so checks wait for both.
    logic [1:0] cfg_written;
    logic nvm_standby;
    logic nvm_prog_enable;
    logic row_mode_enable;
    logic row_prog_start;
    logic busy;
    logic [NVM_CNT_W-1:0] cnt;
    logic [6:0] byte_addr;
    logic [7:0] byte_data;
    logic row_latched;
    logic [3:0] row_addr;
    logic [7:0] row_mask;
    logic [7:0][7:0] row_data;
    logic win_pend;
    dpg_cpu_rsp_t rsp;
    dpg_pm_req_t pm;
    logic [127:0][7:0] nvm_mem;
    logic [127:0][7:0] ram_mem;
  } dpg_state_t;

  dpg_state_t s_ff;
  dpg_state_t nxt_s;

  // Maps a paged address onto one of two 64-byte pages.
  function automatic logic [6:0] page_index(input logic second, input logic [7:0] a);
    page_index = {second, a[5:0]};
  endfunction

  // ==========================================================
  // Next-state logic
  // ==========================================================
  logic nvm_sel;
  logic ram_sel;
  logic nvm_ok;
  logic start_ok;
  logic [6:0] nidx;
  logic [6:0] ridx;

  always_comb
  begin
    nvm_sel = s_ff.page_bank_select[BANK_NVM_PAGE0] | s_ff.page_bank_select[BANK_NVM_PAGE1];
    ram_sel = s_ff.page_bank_select[BANK_RAM_PAGE1] | s_ff.page_bank_select[BANK_RAM_PAGE2];
    // With several bits set the lowest page wins; software must not do that.
    nidx = page_index(~s_ff.page_bank_select[BANK_NVM_PAGE0], cpu_req.addr);
    ridx = page_index(~s_ff.page_bank_select[BANK_RAM_PAGE1], cpu_req.addr);
    nvm_ok = nvm_sel && !s_ff.nvm_standby && !s_ff.busy;
    start_ok = cpu_req.wdata[CTL_ROW_START] && s_ff.nvm_prog_enable
      && s_ff.row_mode_enable;
    nxt_s = s_ff;
    nxt_s.rsp.rvalid = 1'b0;
    nxt_s.pm.rd = 1'b0;
    nxt_s.win_pend = 1'b0;

    // Reads answer one cycle later; window reads take one more for program memory.
    if (cpu_req.rd)
    begin
      nxt_s.rsp.rvalid = 1'b1;
      nxt_s.rsp.rdata = RDATA_NONE;
      if (cpu_req.addr[7:6] == REGION_PAGED)
      begin
        if (nvm_sel)
        begin
          // Reads in row mode see nothing useful, so they return zero.
          if (nvm_ok && !s_ff.row_mode_enable)
          begin
            nxt_s.rsp.rdata = s_ff.nvm_mem[nidx];
          end
        end
        else if (ram_sel)
        begin
          nxt_s.rsp.rdata = s_ff.ram_mem[ridx];
        end
      end
      else if (cpu_req.addr[7:6] == REGION_WINDOW)
      begin
        nxt_s.rsp.rvalid = 1'b0;
        nxt_s.pm.addr = {1'b0, s_ff.window_page_bits, cpu_req.addr[5:0]};
        nxt_s.pm.rd = 1'b1;
        nxt_s.win_pend = 1'b1;
      end
      else if (cpu_req.addr == ADDR_NVM_CTL)
      begin
        nxt_s.rsp.rdata[CTL_BUSY] = s_ff.busy;
      end
      // The two write-only registers read as zero.
    end
    if (s_ff.win_pend)
    begin
      nxt_s.rsp.rvalid = 1'b1;
      nxt_s.rsp.rdata = pm_rdata;
    end

    if (cpu_req.wr)
    begin
      if (cpu_req.addr == ADDR_WIN_POS)
      begin
        nxt_s.window_page_bits = cpu_req.wdata[5:0];
        nxt_s.cfg_written[0] = 1'b1;
      end
      else if (cpu_req.addr == ADDR_BANK_SEL)
      begin
        nxt_s.page_bank_select = cpu_req.wdata;
        nxt_s.cfg_written[1] = 1'b1;
      end
      else if (cpu_req.addr == ADDR_NVM_CTL && !s_ff.busy)
      begin
        nxt_s.nvm_standby = cpu_req.wdata[CTL_STANDBY];
        nxt_s.nvm_prog_enable = cpu_req.wdata[CTL_PROG_ENABLE];
        nxt_s.row_mode_enable = cpu_req.wdata[CTL_ROW_MODE];
        if (cpu_req.wdata[CTL_ROW_MODE] && !s_ff.row_mode_enable)
        begin
          nxt_s.row_mask = 8'h00;
          nxt_s.row_data = '0;
          nxt_s.row_latched = 1'b0;
        end
        if (!cpu_req.wdata[CTL_ROW_MODE])
        begin
          nxt_s.row_latched = 1'b0;
        end
        if (start_ok)
        begin
          nxt_s.row_mode_enable = 1'b1;
          nxt_s.row_prog_start = 1'b1;
          nxt_s.busy = 1'b1;
          nxt_s.cnt = NVM_CNT_W'(PROG_CYCLES - 1);
        end
      end
      else if (cpu_req.addr[7:6] == REGION_PAGED)
      begin
        if (nvm_ok)
        begin
          if (s_ff.row_mode_enable)
          begin
            // The first write fixes the row; writes to other rows are dropped.
            if (!s_ff.row_latched || s_ff.row_addr == nidx[6:3])
            begin
              nxt_s.row_latched = 1'b1;
              nxt_s.row_addr = nidx[6:3];
              nxt_s.row_data[nidx[2:0]] = cpu_req.wdata;
              nxt_s.row_mask[nidx[2:0]] = 1'b1;
            end
          end
          else if (s_ff.nvm_prog_enable)
          begin
            nxt_s.byte_addr = nidx;
            nxt_s.byte_data = cpu_req.wdata;
            nxt_s.busy = 1'b1;
            nxt_s.cnt = NVM_CNT_W'(PROG_CYCLES - 1);
          end
        end
        else if (!nvm_sel && ram_sel)
        begin
          nxt_s.ram_mem[ridx] = cpu_req.wdata;
        end
      end
    end

    // The cell contents change only when the programming time has run out.
    if (s_ff.busy)
    begin
      if (s_ff.cnt == CNT_RESET)
      begin
        nxt_s.busy = 1'b0;
        if (s_ff.row_prog_start)
        begin
          for (int i = 0; i < ROW_BYTES; i++)
          begin
            if (s_ff.row_mask[i])
            begin
              nxt_s.nvm_mem[{s_ff.row_addr, 3'(i)}] = s_ff.row_data[i];
            end
          end
          nxt_s.row_prog_start = 1'b0;
          nxt_s.row_mode_enable = 1'b0;
          nxt_s.row_latched = 1'b0;
          nxt_s.row_mask = 8'h00;
        end
        else
        begin
          nxt_s.nvm_mem[s_ff.byte_addr] = s_ff.byte_data;
        end
      end
      else
      begin
        nxt_s.cnt = s_ff.cnt - NVM_CNT_W'(1);
      end
    end

    // Window, bank, cell array and RAM pages are left as they are.
    if (rst)
    begin
      nxt_s.nvm_standby = 1'b0;
      nxt_s.nvm_prog_enable = 1'b0;
      nxt_s.row_mode_enable = 1'b0;
      nxt_s.row_prog_start = 1'b0;
      nxt_s.busy = 1'b0;
      nxt_s.cnt = CNT_RESET;
      nxt_s.byte_addr = 7'h00;
      nxt_s.byte_data = 8'h00;
      nxt_s.row_latched = 1'b0;
      nxt_s.row_addr = 4'h0;
      nxt_s.row_mask = 8'h00;
      nxt_s.row_data = '0;
      nxt_s.win_pend = 1'b0;
      nxt_s.rsp = '0;
      nxt_s.pm = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s_ff <= nxt_s;
  end

  assign cpu_rsp = s_ff.rsp;
  assign pm_req = s_ff.pm;
  assign nvm_busy = s_ff.busy;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking dpg_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence win_read_s;
    cpu_req.rd && cpu_req.addr[7:6] == REGION_WINDOW && !s_ff.win_pend;
  endsequence

  sequence byte_write_s;
    cpu_req.wr && cpu_req.addr[7:6] == REGION_PAGED && nvm_ok
      && s_ff.nvm_prog_enable && !s_ff.row_mode_enable;
  endsequence

  sequence row_done_s;
    s_ff.busy && s_ff.row_prog_start && s_ff.cnt == CNT_RESET;
  endsequence

  a_win_addr_form: assert property (win_read_s |=> pm_req.rd
    && pm_req.addr == {$past(s_ff.window_page_bits), $past(cpu_req.addr[5:0])})
    else $error("window address not formed from position and low bits");

  a_win_data_back: assert property (win_read_s |-> ##1 !cpu_rsp.rvalid
    ##1 (cpu_rsp.rvalid && cpu_rsp.rdata == $past(pm_rdata)))
    else $error("window read did not return program memory byte");

  a_nvm_read_time: assert property (cpu_req.rd && cpu_req.addr[7:6] == REGION_PAGED
    && nvm_ok && !s_ff.row_mode_enable |=> cpu_rsp.rvalid
    && cpu_rsp.rdata == $past(s_ff.nvm_mem[nidx]))
    else $error("idle cell read not answered next cycle");

  a_byte_start: assert property (byte_write_s |=> nvm_busy
    && s_ff.cnt == NVM_CNT_W'(PROG_CYCLES - 1))
    else $error("byte write did not start programming");

  a_no_prog_off: assert property (cpu_req.wr && cpu_req.addr[7:6] == REGION_PAGED
    && !s_ff.nvm_prog_enable && !s_ff.busy |=> !nvm_busy)
    else $error("write with enable low started a cycle");

  a_busy_hold: assert property (nvm_busy && s_ff.cnt != CNT_RESET |=> nvm_busy
    && s_ff.cnt == $past(s_ff.cnt) - NVM_CNT_W'(1))
    else $error("busy dropped before programming time elapsed");

  a_ctl_locked: assert property (nvm_busy && cpu_req.wr && cpu_req.addr == ADDR_NVM_CTL
    && s_ff.cnt != CNT_RESET |=> $stable(s_ff.nvm_prog_enable)
    && $stable(s_ff.nvm_standby) && $stable(s_ff.row_mode_enable))
    else $error("control changed while busy");

  a_busy_readback: assert property (cpu_req.rd && cpu_req.addr == ADDR_NVM_CTL
    |=> cpu_rsp.rvalid && cpu_rsp.rdata == {6'h00, $past(s_ff.busy), 1'b0})
    else $error("control read does not show busy alone");

  a_start_gate: assert property (cpu_req.wr && cpu_req.addr == ADDR_NVM_CTL && !s_ff.busy
    && !(s_ff.nvm_prog_enable && s_ff.row_mode_enable) |=> !nvm_busy
    && !s_ff.row_prog_start)
    else $error("row start accepted without enable and row mode");

  a_row_end: assert property (row_done_s |=> !nvm_busy && !s_ff.row_prog_start
    && !s_ff.row_mode_enable)
    else $error("row cycle end did not clear start and row mode");

  a_row_clear: assert property ($rose(s_ff.row_mode_enable) && !s_ff.row_prog_start
    |-> s_ff.row_mask == 8'h00)
    else $error("row latches not cleared on row mode entry");

  a_row_lock: assert property (s_ff.row_mode_enable && s_ff.row_latched && !s_ff.busy
    && cpu_req.wr && cpu_req.addr[7:6] == REGION_PAGED && nvm_ok
    && s_ff.row_addr != nidx[6:3] |=> $stable(s_ff.row_mask))
    else $error("write to another row was latched");

  a_keep_rst: assert property (disable iff (1'b0) $past(rst) && !$past(cpu_req.wr)
    && s_ff.cfg_written == 2'h3 |-> s_ff.window_page_bits
    == $past(s_ff.window_page_bits) && s_ff.page_bank_select
    == $past(s_ff.page_bank_select))
    else $error("window or bank changed by reset");

endmodule // dpg_paging_ctrl

`default_nettype wire

// >>> dpg_pm_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Program memory behind the read-only window
// ==========================================================
module dpg_pm_model (
  input wire logic sys_clk,
  input wire dpg_pkg::dpg_pm_req_t pm_req,
  output logic [7:0] pm_rdata
);
  import dpg_pkg::*;
  logic [7:0] junk_ff = 8'h5a;
  // Outside a strobe the bus shows a changing pattern, so stale data never matches by luck.
  always_ff @(posedge sys_clk)
  begin
    junk_ff <= ~junk_ff + 8'h01;
  end
  always_comb
  begin
    pm_rdata = pm_req.rd ? (pm_req.addr[7:0] ^ {3'h0, pm_req.addr[12:8]}) : junk_ff;
  end
endmodule // dpg_pm_model
`default_nettype wire

// >>> test_data_space_paging_eeprom_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_data_space_paging_eeprom_ctrl;
  import dpg_pkg::*;
  // A short programming time keeps the run small; the positive counts given to prog_check derive from it.
  localparam int PC = 16;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  dpg_cpu_req_t cpu_req = '0;
  dpg_cpu_rsp_t cpu_rsp;
  dpg_pm_req_t pm_req;
  logic [7:0] pm_rdata;
  logic nvm_busy;
  logic [12:0] pm_seen = '0;
  int num_errors = 0;
  int n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  dpg_paging_ctrl #(.PROG_CYCLES(PC)) uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .cpu_req(cpu_req),
    .cpu_rsp(cpu_rsp),
    .pm_req(pm_req),
    .pm_rdata(pm_rdata),
    .nvm_busy(nvm_busy)
  );
  dpg_pm_model pm (
    .sys_clk(sys_clk),
    .pm_req(pm_req),
    .pm_rdata(pm_rdata)
  );
  always @(posedge sys_clk)
    if (pm_req.rd === 1'b1)
      pm_seen <= pm_req.addr;
  // ==========================================================
  // Bus tasks
  // ==========================================================
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge sys_clk);
    cpu_req = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
    @(negedge sys_clk);
    cpu_req.wr = 1'b0;
  end
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    int i;
  begin
    @(negedge sys_clk);
    cpu_req = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    @(negedge sys_clk);
    cpu_req.rd = 1'b0;
    for (i = 0; i < 4 && cpu_rsp.rvalid !== 1'b1; i++)
      @(negedge sys_clk);
    `CHK("rvalid", 1'b1, cpu_rsp.rvalid)
    `CHK("rdata", exp, cpu_rsp.rdata)
  end
  endtask
  // A negative count only waits for the cycle to end.
  task automatic prog_check(input int exp_cycles);
    int i;
    int n;
  begin
    n = 0;
    for (i = 0; i < 4 && nvm_busy !== 1'b1; i++)
      @(negedge sys_clk);
    for (i = 0; i < 4 * PC && nvm_busy === 1'b1; i++)
    begin
      n++;
      @(negedge sys_clk);
    end
    if (exp_cycles >= 0)
      `CHK("busy cycles", exp_cycles, n)
  end
  endtask
  task automatic pulse_rst;
  begin
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
  end
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_window;
  begin
    bus_wr(8'hc9, 8'h28);
    bus_rd(8'h59, 8'h13);
    `CHK("pm addr", 13'ha19, pm_seen)
    bus_wr(8'hc9, 8'he8);
    bus_rd(8'h59, 8'h13);
    bus_wr(8'hc9, 8'hff);
    bus_rd(8'h40, 8'hcf);
    pulse_rst();
    bus_rd(8'h40, 8'hcf);
  end
  endtask
  task automatic t_ram;
  begin
    bus_wr(8'hcb, 8'h08);
    bus_wr(8'h05, 8'ha5);
    bus_wr(8'hcb, 8'h10);
    bus_wr(8'h05, 8'h5a);
    bus_rd(8'h05, 8'h5a);
    bus_wr(8'hcb, 8'h08);
    bus_rd(8'h05, 8'ha5);
    pulse_rst();
    bus_rd(8'h05, 8'ha5);
    bus_rd(8'hcb, 8'h00);
  end
  endtask
  task automatic t_byte;
  begin
    bus_wr(8'hcb, 8'h01);
    bus_wr(8'hdf, 8'h01);
    bus_wr(8'h07, 8'h3c);
    prog_check(PC);
    bus_rd(8'h07, 8'h3c);
    bus_wr(8'hcb, 8'h02);
    bus_wr(8'h07, 8'hc3);
    prog_check(PC);
    bus_rd(8'h07, 8'hc3);
    bus_wr(8'hcb, 8'h01);
    bus_rd(8'h07, 8'h3c);
    bus_wr(8'hdf, 8'h00);
    bus_wr(8'h07, 8'hff);
    prog_check(0);
    bus_rd(8'h07, 8'h3c);
    bus_wr(8'hdf, 8'h41);
    bus_rd(8'h07, 8'h00);
    bus_wr(8'h07, 8'h11);
    prog_check(0);
    bus_wr(8'hcb, 8'h00);
    bus_wr(8'hdf, 8'h01);
    bus_wr(8'h07, 8'h22);
    prog_check(0);
  end
  endtask
  task automatic t_row;
  begin
    bus_wr(8'hcb, 8'h01);
    bus_wr(8'h19, 8'h77);
    prog_check(PC);
    bus_wr(8'h20, 8'h44);
    prog_check(PC);
    bus_wr(8'hdf, 8'h05);
    bus_wr(8'h18, 8'h81);
    bus_wr(8'h1a, 8'h82);
    bus_wr(8'h1b, 8'h83);
    bus_wr(8'h20, 8'h99);
    bus_wr(8'hdf, 8'h0d);
    bus_rd(8'hdf, 8'h02);
    bus_wr(8'hdf, 8'h40);
    bus_rd(8'h18, 8'h00);
    prog_check(-1);
    bus_rd(8'h18, 8'h81);
    bus_rd(8'h19, 8'h77);
    bus_rd(8'h1a, 8'h82);
    bus_rd(8'h1b, 8'h83);
    bus_rd(8'h20, 8'h44);
    bus_rd(8'hdf, 8'h00);
    bus_wr(8'hdf, 8'h09);
    prog_check(0);
    bus_wr(8'hdf, 8'h0c);
    prog_check(0);
  end
  endtask
  // ==========================================================
  // Run control
  // ==========================================================
  task automatic test_done;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    t_window();
    t_ram();
    t_byte();
    t_row();
    test_done();
  end
  // The scenarios need well under 2000 cycles; the limit leaves ample margin.
  initial
  begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule // test_data_space_paging_eeprom_ctrl
`default_nettype wire
